// ==== include/spdst_cfg.svh ====
// Register offsets, reset values, threshold limits and codes of the speed status block
`ifndef SPDST_CFG_SVH
`define SPDST_CFG_SVH
`define SPDST_OFF_ROT 8'h00
`define SPDST_OFF_ZERO 8'h04
`define SPDST_OFF_COIN 8'h08
`define SPDST_OFF_NEAR 8'h0c
`define SPDST_OFF_DOSEL0 8'h10
`define SPDST_OFF_DOSEL1 8'h14
`define SPDST_OFF_FLAGS 8'h18
`define SPDST_OFF_IRQ_STAT 8'h1c
`define SPDST_OFF_IRQ_CLR 8'h20
`define SPDST_OFF_IRQ_EN 8'h24
`define SPDST_OFF_FEED 8'h28
`define SPDST_OFF_CMD 8'h2c
`define SPDST_RST_ROT 16'h0014
`define SPDST_RST_ZERO 16'h000a
`define SPDST_RST_COIN 16'h000a
`define SPDST_RST_NEAR 16'h0064
`define SPDST_MIN_THR 16'h0000
`define SPDST_MAX_ROT 16'h03e8
`define SPDST_MAX_ZERO 16'h1770
`define SPDST_MAX_COIN 16'h0064
`define SPDST_MIN_NEAR 16'h000a
`define SPDST_MAX_NEAR 16'h1770
`define SPDST_FN_ROT 8'h84
`define SPDST_FN_ZERO 8'h85
`define SPDST_FN_COIN 8'h88
`define SPDST_FN_NEAR 8'h89
`define SPDST_FN_NONE 8'h00
`define SPDST_DO_NUM 4
`define SPDST_RESP_OKAY 2'b00
`define SPDST_RESP_SLVERR 2'b10
`endif

// ==== include/spdst_pkg.sv ====
// Types shared by the speed status block
package spdst_pkg;
  // Four status flags, bit 0 rotation, 1 zero, 2 coincident, 3 near
  typedef struct packed {
    logic speedNearFlag;
    logic speedCoincidentFlag;
    logic zeroSpeedFlag;
    logic rotationDetectedFlag;
  } spdst_flags_t;

  // Speed sample from the drive control loop
  typedef struct packed {
    logic sampleValid;
    logic signed [15:0] filteredSpeed;
    logic signed [15:0] actualSpeed;
    logic signed [15:0] speedCommand;
  } spdst_speed_t;

  // Write channel states of the register slave
  typedef enum logic [1:0] {SPDST_W_IDLE, SPDST_W_RESP} spdst_wstate_t;
endpackage

// ==== rtl/spdst_speed_status.sv ====
// Speed status comparators with digital output mapping and AXI4-Lite registers
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
// 0x00 rotation threshold, lanes 0-1, clamped to 0..1000
// 0x04 zero-speed threshold, lanes 0-1, clamped to 0..6000
// 0x08 coincidence threshold, lanes 0-1, clamped to 0..100
// 0x0c approach threshold, lanes 0-1, clamped to 10..6000
// 0x10 terminal function select, byte i for terminal i
// 0x14 reserved, reads zero, writes ignored
// 0x18 flags in bits 3:0, terminal levels in bits 7:4, read only
// 0x1c interrupt status, sticky, read only
// 0x20 interrupt clear, write one to clear, reads zero
// 0x24 interrupt enable, same layout as status
// 0x28 last filtered speed seen with a valid sample, read only
// 0x2c last speed command seen with a valid sample, read only
// Anything above 0x2c or not word aligned answers SLVERR
//
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Edge N with sampleValid high: flags take the new comparison
// Edge N+1: terminal levels follow the flags
// A threshold written at edge M is used by samples after edge M
// Write: address and data taken in either order, one each
// Write: register updated one edge after both halves are held
// Write: response held until the master raises bready
// Read: data latched at the address edge, held until rready
//
// ----------------------------------------------------------------
// Hazards and limits
// ----------------------------------------------------------------
// Flags read zero after reset until the first valid sample
// The first sample usually raises status bits, since flags change
// A flag change and a clear in one cycle keep the status bit set
// Out-of-range writes are clamped, never refused
// Unknown function codes leave their terminal low
// Several terminals may carry the same function
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`include "spdst_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module spdst_speed_status (
  input wire logic core_clk,
  input wire logic rst_n,
  // Speed sample, same clock domain
  input wire spdst_pkg::spdst_speed_t speedIn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status flags and terminals
  output spdst_pkg::spdst_flags_t flags,
  output logic [3:0] digitalOut,
  output logic irq
);
  import spdst_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rotationDetectThreshold; // Rotation judgment level
    logic [15:0] zeroSpeedThreshold; // Zero-speed level
    logic [15:0] speedCoincideThreshold; // Coincidence window
    logic [15:0] speedApproachThreshold; // Approach level
    logic [31:0] terminalFunction; // Function code per terminal, 8 bits each
    spdst_flags_t flagState; // Current flags
    logic [3:0] doState; // Terminal levels
    logic [3:0] irqStatus; // Sticky flag change events
    logic [3:0] irqEnable; // Interrupt enables
    logic [15:0] feedSpeed; // Last filtered speed seen
    logic [15:0] cmdSpeed; // Last command seen
    spdst_wstate_t wState; // Write channel state
    logic awTaken; // Write address held
    logic wTaken; // Write data held
    logic [7:0] awAddr; // Held write address
    logic [31:0] wData; // Held write data
    logic [3:0] wStrb; // Held byte enables
    logic [1:0] bResp; // Write response code
    logic rValid; // Read data valid
    logic [31:0] rData; // Read data
    logic [1:0] rResp; // Read response code
  } spdst_state_t;

  spdst_state_t st; // Registered state
  spdst_state_t next_st; // Next state

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Magnitude of a signed speed, kept in 17 bits so the most negative value stays exact
  function automatic logic [16:0] absVal(input logic signed [16:0] v);
    absVal = v[16] ? 17'(-v) : 17'(v);
  endfunction

  // Clamp a threshold write into its legal range
  function automatic logic [15:0] clampThr(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
    if (v < lo) begin
      clampThr = lo;
    end else if (v > hi) begin
      clampThr = hi;
    end else begin
      clampThr = v;
    end
  endfunction

  // Merge byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Is an address one of the mapped registers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `SPDST_OFF_CMD);
  endfunction

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  logic [16:0] absFiltered; // |filtered speed|
  logic [16:0] absActual; // |actual speed|
  logic [16:0] absDeviation; // |filtered - command|
  spdst_flags_t cmpFlags; // Comparison results
  logic [3:0] doLevels; // Terminal levels from mapping

  always_comb begin
    absFiltered = absVal(17'(speedIn.filteredSpeed));
    absActual = absVal(17'(speedIn.actualSpeed));
    absDeviation = absVal(17'(speedIn.filteredSpeed) - 17'(speedIn.speedCommand));
    cmpFlags.rotationDetectedFlag = absFiltered >= {1'b0, st.rotationDetectThreshold};
    cmpFlags.zeroSpeedFlag = absActual < {1'b0, st.zeroSpeedThreshold};
    cmpFlags.speedCoincidentFlag = absDeviation <= {1'b0, st.speedCoincideThreshold};
    cmpFlags.speedNearFlag = absFiltered > {1'b0, st.speedApproachThreshold};
  end

  // Each terminal shows the flag whose function code is assigned to it
  always_comb begin
    for (int i = 0; i < `SPDST_DO_NUM; i++) begin
      case (st.terminalFunction[i*8 +: 8])
        `SPDST_FN_ROT: doLevels[i] = st.flagState.rotationDetectedFlag;
        `SPDST_FN_ZERO: doLevels[i] = st.flagState.zeroSpeedFlag;
        `SPDST_FN_COIN: doLevels[i] = st.flagState.speedCoincidentFlag;
        `SPDST_FN_NEAR: doLevels[i] = st.flagState.speedNearFlag;
        default: doLevels[i] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wFire; // Both write halves held, no response pending
  logic [31:0] readWord; // Read mux output
  logic [3:0] flagEvents; // Flags that changed this cycle
  logic [3:0] clrMask; // Interrupt bits cleared by software

  always_comb begin
    next_st = st;
    readWord = 32'h0000_0000;
    clrMask = 4'h0;
    // Evaluate once per valid sample with the thresholds now in force
    flagEvents = 4'h0;
    if (speedIn.sampleValid) begin
      next_st.flagState = cmpFlags;
      next_st.feedSpeed = speedIn.filteredSpeed;
      next_st.cmdSpeed = speedIn.speedCommand;
      flagEvents = cmpFlags ^ st.flagState;
    end
    next_st.doState = doLevels;
    // Address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awTaken = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wTaken = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    wFire = st.awTaken && st.wTaken && (st.wState == SPDST_W_IDLE);
    case (st.wState)
      SPDST_W_IDLE: begin
        if (wFire) begin
          next_st.wState = SPDST_W_RESP;
          next_st.awTaken = 1'b0;
          next_st.wTaken = 1'b0;
          next_st.bResp = mapped(st.awAddr) ? `SPDST_RESP_OKAY : `SPDST_RESP_SLVERR;
          case (st.awAddr)
            `SPDST_OFF_ROT: next_st.rotationDetectThreshold = clampThr(
              merge16(st.rotationDetectThreshold, st.wData, st.wStrb),
              `SPDST_MIN_THR, `SPDST_MAX_ROT);
            `SPDST_OFF_ZERO: next_st.zeroSpeedThreshold = clampThr(
              merge16(st.zeroSpeedThreshold, st.wData, st.wStrb),
              `SPDST_MIN_THR, `SPDST_MAX_ZERO);
            `SPDST_OFF_COIN: next_st.speedCoincideThreshold = clampThr(
              merge16(st.speedCoincideThreshold, st.wData, st.wStrb),
              `SPDST_MIN_THR, `SPDST_MAX_COIN);
            `SPDST_OFF_NEAR: next_st.speedApproachThreshold = clampThr(
              merge16(st.speedApproachThreshold, st.wData, st.wStrb),
              `SPDST_MIN_NEAR, `SPDST_MAX_NEAR);
            `SPDST_OFF_DOSEL0: begin
              for (int b = 0; b < 4; b++) begin
                if (st.wStrb[b]) begin
                  next_st.terminalFunction[b*8 +: 8] = st.wData[b*8 +: 8];
                end
              end
            end
            `SPDST_OFF_IRQ_CLR: clrMask = st.wStrb[0] ? st.wData[3:0] : 4'h0;
            `SPDST_OFF_IRQ_EN: begin
              if (st.wStrb[0]) begin
                next_st.irqEnable = st.wData[3:0];
              end
            end
            default: ; // Read-only or unmapped: no effect
          endcase
        end
      end
      SPDST_W_RESP: begin
        // Hold response until the master takes it
        if (s_axi_bready) begin
          next_st.wState = SPDST_W_IDLE;
        end
      end
      default: next_st.wState = SPDST_W_IDLE;
    endcase
    // Sticky events: a new event wins over a clear in the same cycle
    next_st.irqStatus = (st.irqStatus & ~clrMask) | flagEvents;
    // Read channel
    // Data is latched at the address edge, so a flag that moves
    // while rvalid waits does not tear the returned word
    case (s_axi_araddr)
      `SPDST_OFF_ROT: readWord = {16'h0000, st.rotationDetectThreshold};
      `SPDST_OFF_ZERO: readWord = {16'h0000, st.zeroSpeedThreshold};
      `SPDST_OFF_COIN: readWord = {16'h0000, st.speedCoincideThreshold};
      `SPDST_OFF_NEAR: readWord = {16'h0000, st.speedApproachThreshold};
      `SPDST_OFF_DOSEL0: readWord = st.terminalFunction;
      `SPDST_OFF_FLAGS: readWord = {24'h000000, st.doState, st.flagState};
      `SPDST_OFF_IRQ_STAT: readWord = {28'h0000000, st.irqStatus};
      `SPDST_OFF_IRQ_EN: readWord = {28'h0000000, st.irqEnable};
      `SPDST_OFF_FEED: readWord = {16'h0000, st.feedSpeed};
      `SPDST_OFF_CMD: readWord = {16'h0000, st.cmdSpeed};
      default: readWord = 32'h0000_0000;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rValid = 1'b1;
      next_st.rData = readWord;
      next_st.rResp = mapped(s_axi_araddr) ? `SPDST_RESP_OKAY : `SPDST_RESP_SLVERR;
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.rotationDetectThreshold <= `SPDST_RST_ROT;
      st.zeroSpeedThreshold <= `SPDST_RST_ZERO;
      st.speedCoincideThreshold <= `SPDST_RST_COIN;
      st.speedApproachThreshold <= `SPDST_RST_NEAR;
      st.wState <= SPDST_W_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready signals are decoded from registers only, never from valid,
  // so no combinational path runs from master back to master
  assign s_axi_awready = !st.awTaken && (st.wState == SPDST_W_IDLE);
  assign s_axi_wready = !st.wTaken && (st.wState == SPDST_W_IDLE);
  assign s_axi_bvalid = (st.wState == SPDST_W_RESP);
  assign s_axi_bresp = st.bResp;
  assign s_axi_arready = !st.rValid;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;
  assign flags = st.flagState;
  assign digitalOut = st.doState;
  // Level interrupt: high while any enabled status bit is set
  assign irq = |(st.irqStatus & st.irqEnable);

endmodule // spdst_speed_status

`default_nettype wire

// ==== sim/spdst_speed_status_assertions.sv ====
// Concurrent checks on the ports of the speed status block
`timescale 1ns/1ps
`default_nettype none
module spdst_speed_status_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire spdst_pkg::spdst_speed_t speedIn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire spdst_pkg::spdst_flags_t flags
);
  import spdst_pkg::*;
  // Magnitudes widened by one bit so the most negative sample stays exact
  logic [16:0] absFilt;
  logic [16:0] absAct;
  logic [16:0] absDev;
  logic sv;
  function automatic logic [16:0] mag(input logic signed [16:0] y);
    return y[16] ? -y : y;
  endfunction
  assign absFilt = mag(17'(speedIn.filteredSpeed));
  assign absAct = mag(17'(speedIn.actualSpeed));
  assign absDev = mag(17'(speedIn.filteredSpeed) - 17'(speedIn.speedCommand));
  assign sv = speedIn.sampleValid;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // --------------------------------------------------------------
  // Flag relations that hold for any legal threshold, then write and read handshake checks
  // --------------------------------------------------------------
  rot_max_a: assert property (sv && absFilt >= 17'd1000 |=> flags.rotationDetectedFlag)
    else $error("rotation flag low at top threshold");
  zero_off_a: assert property (sv && absAct >= 17'd6000 |=> !flags.zeroSpeedFlag)
    else $error("zero flag high at top threshold");
  coin_eq_a: assert property (sv && absDev == 17'd0 |=> flags.speedCoincidentFlag)
    else $error("coincident flag low with no deviation");
  coin_off_a: assert property (sv && absDev > 17'd100 |=> !flags.speedCoincidentFlag)
    else $error("coincident flag high on large deviation");
  near_low_a: assert property (sv && absFilt <= 17'd10 |=> !flags.speedNearFlag)
    else $error("near flag high under lowest threshold");
  near_hi_a: assert property (sv && absFilt > 17'd6000 |=> flags.speedNearFlag)
    else $error("near flag low over top threshold");
  flag_hold_a: assert property (!sv |=> $stable(flags))
    else $error("flags moved without a sample");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##[0:1] s_axi_bvalid) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  // Main scenarios reached
  cover property (sv && flags.zeroSpeedFlag);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (sv && absFilt > 17'd6000);
endmodule // spdst_speed_status_assertions
bind spdst_speed_status spdst_speed_status_assertions u_chk (.core_clk, .rst_n, .speedIn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .flags);
`default_nettype wire

// ==== sim/spdst_host_model.sv ====
// Host controller model that samples the drive's output terminals
`timescale 1ns/1ps
`default_nettype none
module spdst_host_model (
  input wire logic core_clk,
  input wire logic [3:0] digitalOut,
  output logic [3:0] seenLevels
);
  // Input latch of the host, one sample per cycle
  always_ff @(posedge core_clk) begin
    seenLevels <= digitalOut;
  end
endmodule // spdst_host_model
`default_nettype wire

// ==== sim/spdst_speed_status_tb.sv ====
// Testbench of the speed status block
`timescale 1ns/1ps
`default_nettype none
module spdst_speed_status_tb;
  import spdst_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  spdst_speed_t speedIn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] digitalOut, seenLevels;
  spdst_flags_t flags;
  int errors = 0, tests_run = 0, cyc = 0, rth = 20, zth = 10, cth = 10, nth = 100;
  // Speed table: filtered, actual, command
  int fs[6] = '{20, -19, 100, -7000, 1000, -1000};
  int as[6] = '{10, -9, 0, 500, 6000, -5999};
  int cs[6] = '{20, -8, 90, -90, 1000, -1000};
  always #2 core_clk = ~core_clk;
  spdst_speed_status u_dut (.core_clk, .rst_n, .speedIn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flags,
    .digitalOut, .irq);
  spdst_host_model u_host (.core_clk, .digitalOut, .seenLevels);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask
  // Read and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, e);
  endtask
  // Expected flags {near, coincident, zero, rotation} from current thresholds
  function automatic logic [3:0] expf(input int f, input int a, input int c);
    int af, aa, dv;
    af = f < 0 ? -f : f;
    aa = a < 0 ? -a : a;
    dv = f - c < 0 ? c - f : f - c;
    return {af > nth, dv <= cth, aa < zth, af >= rth};
  endfunction
  // One valid sample; m: 0 terminals idle, 1 one flag each, 2 all on rotation
  task automatic smp(input int f, input int a, input int c, input logic [1:0] m);
    logic [3:0] ex;
    logic [3:0] eo;
    ex = expf(f, a, c);
    eo = m == 2'd2 ? {4{ex[0]}} : (m[0] ? ex : 4'h0);
    @(posedge core_clk);
    speedIn <= {1'b1, 16'(f), 16'(a), 16'(c)};
    @(posedge core_clk);
    speedIn.sampleValid <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(flags, ex);
    chk(digitalOut, eo);
    chk(seenLevels, eo);
  endtask
  task automatic runt(input logic [1:0] m);
    for (int i = 0; i < 6; i++) smp(fs[i], as[i], cs[i], m);
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(8'h00, 32'd20, 2'b00);
    rdc(8'h04, 32'd10, 2'b00);
    rdc(8'h08, 32'd10, 2'b00);
    rdc(8'h0c, 32'd100, 2'b00);
    wr(8'h24, 32'hf, 2'b00);
    runt(2'd0);
    wr(8'h10, 32'h89888584, 2'b00);
    runt(2'd1);
    wr(8'h00, 32'd2000, 2'b00);
    wr(8'h04, 32'd6000, 2'b00);
    wr(8'h08, 32'd0, 2'b00);
    wr(8'h0c, 32'd5, 2'b00);
    rth = 1000;
    zth = 6000;
    cth = 0;
    nth = 10;
    rdc(8'h00, 32'd1000, 2'b00);
    rdc(8'h0c, 32'd10, 2'b00);
    runt(2'd1);
    wr(8'h10, 32'h84848484, 2'b00);
    smp(5, 0, 0, 2'd2);
    smp(1000, 0, 1000, 2'd2);
    chk(irq, 1'b1);
    wr(8'h24, 32'h0, 2'b00);
    chk(irq, 1'b0);
    wr(8'h24, 32'hf, 2'b00);
    chk(irq, 1'b1);
    wr(8'h20, 32'hf, 2'b00);
    chk(irq, 1'b0);
    rdc(8'h1c, 32'h0, 2'b00);
    rdc(8'h30, 32'h0, 2'b10);
    wr(8'h30, 32'h1, 2'b10);
    wr(8'h18, 32'h0, 2'b00);
    rdc(8'h18, 32'hff, 2'b00);
    complete_run();
  end
endmodule // spdst_speed_status_tb
`default_nettype wire
